// *** src/_unused_guard_placeholder_none.sv ***
// holds no logic; the adapter lives in the other source files

// *** src/fade_adapter_consts.svh ***
// constants for the fade channel port adapter
`ifndef FADE_ADAPTER_CONSTS_SVH
`define FADE_ADAPTER_CONSTS_SVH
`define ADPT_BASE_ADDR 16'h0A00
`define ADPT_ADDR_MASK 16'hFFFC
`define ADDR_PORT_BIT 1
`define ADDR_CTRL_BIT 0
`define CTRL_IRQ_EN_BIT 0
`define CTRL_EDGE_BIT 1
`define CTRL_DATA_SEL_BIT 2
`define CTRL_WR_MASK 8'h3F
`define CTRL_FLAG_BIT 7
`define CTRL_PULSE_MODE 3'h5
`define CTRL_HOLD_MODE 3'h7
`define REG_RESET 8'h00
`define CMP_BIT 7
`define FLAG_KEY_BIT 1
`define FLAG_ON_BIT 2
`define FLAG_SEL_LO_BIT 2
`define FLAG_SEL_HI_BIT 3
`define FLAG_DOWN_BIT 4
`define FLAG_BLINK_BIT 5
`endif

// *** src/fade_adapter_pkg.sv ***
// types shared by the fade channel port adapter modules
package fade_adapter_pkg;
  typedef enum logic [1:0] {
    TGT_DIR = 2'h0,
    TGT_DATA = 2'h1,
    TGT_CTRL = 2'h3
  } target_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] dir;
  } lane_state_t;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic tick_prev;
    logic strobe;
    logic [7:0] rdata;
  } adapter_state_t;
endpackage : fade_adapter_pkg

// *** src/fade_channel_port_adapter.sv ***
// fade channel port adapter: channel number port, flag port, timer irq
// How it works
// - four addresses, upper half of fade block
// - address bit 1 picks channel or flag port
// - address bit 0 picks control, else bit 2
// - control bit 2 low: direction, high: data
// - direction bit: zero input, one output; flag bit 7 is always input
// - control 101 pulses done strobe on data read
// - flag bit 7 is the comparator input
// - flag outputs drive blink, down, on, key flags
// - flag bits 2 and 3 pick digitised level
// - control bit 0 high: tick edge raises interrupt request
// - inhibit output holds timer until released
// - tick sets control bit 7; flag data read clears
`timescale 1ns/1ps
`include "fade_adapter_consts.svh"
module fade_channel_port_adapter (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // processor bus
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_valid,
  input wire logic cpu_read,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  // channel number port
  input wire logic [7:0] chan_pin_in,
  output logic [7:0] chan_pin_out,
  output logic [7:0] chan_pin_oe_n,
  output logic channel_done_strobe,
  // flag port
  input wire logic [7:0] flag_pin_in,
  output logic [7:0] flag_pin_out,
  output logic [7:0] flag_pin_oe_n,
  output logic blink_flag,
  output logic down_fade_flag,
  output logic mimic_on_flag,
  output logic key_select_flag,
  output logic [1:0] digitise_select,
  // timer
  input wire logic timer_tick_input,
  output logic timer_inhibit_output,
  output logic timer_interrupt_request
);
  fade_adapter_pkg::adapter_state_t s_q;
  fade_adapter_pkg::adapter_state_t s_d;
  fade_adapter_pkg::target_t tgt;
  logic hit;
  logic port_b;
  logic wr;
  logic rd;
  logic tick_edge;
  logic rd_chan_data;
  logic rd_flag_data;
  logic [7:0] sel_ctrl;

  lane_if lane_a ();
  lane_if lane_b ();

  function automatic fade_adapter_pkg::target_t decode_target(
    input logic ctrl_sel, input logic data_sel);
    if (ctrl_sel) begin
      return fade_adapter_pkg::TGT_CTRL;
    end else if (data_sel) begin
      return fade_adapter_pkg::TGT_DATA;
    end
    return fade_adapter_pkg::TGT_DIR;
  endfunction : decode_target

  function automatic logic [7:0] ctrl_write(input logic [7:0] old,
                                            input logic [7:0] data);
    return (data & `CTRL_WR_MASK) | (old & ~`CTRL_WR_MASK);
  endfunction : ctrl_write

  // full decode so no alias of the four locations appears elsewhere
  assign hit = cpu_valid &&
    ((cpu_addr & `ADPT_ADDR_MASK) == `ADPT_BASE_ADDR);
  assign port_b = cpu_addr[`ADDR_PORT_BIT];
  assign sel_ctrl = port_b ? s_q.ctrl_b : s_q.ctrl_a;
  assign tgt = decode_target(cpu_addr[`ADDR_CTRL_BIT],
    sel_ctrl[`CTRL_DATA_SEL_BIT]);
  assign wr = hit && !cpu_read;
  assign rd = hit && cpu_read;
  assign rd_chan_data = rd && !port_b && tgt == fade_adapter_pkg::TGT_DATA;
  assign rd_flag_data = rd && port_b && tgt == fade_adapter_pkg::TGT_DATA;

  // edge bit low selects the falling edge of the tick
  assign tick_edge = s_q.ctrl_b[`CTRL_EDGE_BIT] ?
    (timer_tick_input && !s_q.tick_prev) :
    (!timer_tick_input && s_q.tick_prev);

  assign lane_a.wr_dir = wr && !port_b && tgt == fade_adapter_pkg::TGT_DIR;
  assign lane_a.wr_out = wr && !port_b && tgt == fade_adapter_pkg::TGT_DATA;
  assign lane_a.wdata = cpu_wdata;
  assign lane_a.pin_in = chan_pin_in;
  assign lane_b.wr_dir = wr && port_b && tgt == fade_adapter_pkg::TGT_DIR;
  assign lane_b.wr_out = wr && port_b && tgt == fade_adapter_pkg::TGT_DATA;
  assign lane_b.wdata = cpu_wdata;
  assign lane_b.pin_in = flag_pin_in;

  port_lane #(.WIDTH(8)) u_chan_lane (
    .mclk(mclk),
    .reset_n(reset_n),
    .lp(lane_a)
  );

  port_lane #(.WIDTH(8)) u_flag_lane (
    .mclk(mclk),
    .reset_n(reset_n),
    .lp(lane_b)
  );

  always_comb begin
    s_d = s_q;
    s_d.tick_prev = timer_tick_input;
    s_d.strobe = rd_chan_data &&
      s_q.ctrl_a[5:3] == `CTRL_PULSE_MODE;
    if (wr && tgt == fade_adapter_pkg::TGT_CTRL) begin
      if (port_b) begin
        s_d.ctrl_b = ctrl_write(s_q.ctrl_b, cpu_wdata);
      end else begin
        s_d.ctrl_a = ctrl_write(s_q.ctrl_a, cpu_wdata);
      end
    end
    // a tick in the clearing cycle must not be lost, so set wins
    if (rd_flag_data) begin
      s_d.ctrl_b[`CTRL_FLAG_BIT] = 1'b0;
    end
    if (tick_edge) begin
      s_d.ctrl_b[`CTRL_FLAG_BIT] = 1'b1;
    end
    if (rd) begin
      unique case (tgt)
        fade_adapter_pkg::TGT_CTRL: s_d.rdata = sel_ctrl;
        fade_adapter_pkg::TGT_DIR: begin
          s_d.rdata = port_b ? lane_b.dir_q : lane_a.dir_q;
        end
        fade_adapter_pkg::TGT_DATA: begin
          s_d.rdata = port_b ?
            {flag_pin_in[`CMP_BIT], lane_b.read_val[6:0]} :
            lane_a.read_val;
        end
        default: s_d.rdata = `REG_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{ctrl_a: `REG_RESET, ctrl_b: `REG_RESET, tick_prev: 1'b0,
               strobe: 1'b0, rdata: `REG_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign cpu_rdata = s_q.rdata;
  assign chan_pin_out = lane_a.out_q;
  assign chan_pin_oe_n = ~lane_a.dir_q;
  assign flag_pin_out = lane_b.out_q;
  // the comparator line is never driven, whatever software loads
  assign flag_pin_oe_n = ~lane_b.dir_q | 8'h80;
  assign channel_done_strobe = s_q.strobe ||
    s_q.ctrl_a[5:3] == `CTRL_HOLD_MODE;
  assign timer_inhibit_output = s_q.ctrl_b[5:3] == `CTRL_HOLD_MODE;
  assign timer_interrupt_request = s_q.ctrl_b[`CTRL_FLAG_BIT] &&
    s_q.ctrl_b[`CTRL_IRQ_EN_BIT];
  assign blink_flag = lane_b.out_q[`FLAG_BLINK_BIT];
  assign down_fade_flag = lane_b.out_q[`FLAG_DOWN_BIT];
  assign mimic_on_flag = lane_b.out_q[`FLAG_ON_BIT];
  assign key_select_flag = lane_b.out_q[`FLAG_KEY_BIT];
  assign digitise_select =
    lane_b.out_q[`FLAG_SEL_HI_BIT:`FLAG_SEL_LO_BIT];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_tick_armed;
    tick_edge && s_q.ctrl_b[`CTRL_IRQ_EN_BIT] && !wr;
  endsequence
  sequence s_flag_read_quiet;
    rd_flag_data && !tick_edge;
  endsequence

  a_outside_ignored: assert property (cpu_valid && !hit |=>
    $stable(cpu_rdata) && $stable(chan_pin_out) && $stable(flag_pin_out))
    else $error("access outside the four locations had an effect");
  a_port_a_write: assert property (lane_a.wr_out |=>
    chan_pin_out == $past(cpu_wdata) && $stable(flag_pin_out))
    else $error("channel port write went astray");
  a_ctrl_b_write: assert property (wr && port_b &&
    cpu_addr[`ADDR_CTRL_BIT] |=> s_q.ctrl_b[5:0] == $past(cpu_wdata[5:0]))
    else $error("flag control write lost");
  a_dir_routing: assert property (wr && !port_b &&
    !cpu_addr[`ADDR_CTRL_BIT] && !s_q.ctrl_a[`CTRL_DATA_SEL_BIT] |=>
    chan_pin_oe_n == ~$past(cpu_wdata))
    else $error("direction write did not reach direction register");
  a_strobe_pulse: assert property (rd_chan_data &&
    s_q.ctrl_a[5:3] == `CTRL_PULSE_MODE |=> channel_done_strobe)
    else $error("channel done strobe missing after read");
  a_cmp_readback: assert property (rd_flag_data |=>
    cpu_rdata[`CMP_BIT] == $past(flag_pin_in[`CMP_BIT]))
    else $error("comparator bit not read from pin");
  a_tick_raises_irq: assert property (s_tick_armed |=>
    timer_interrupt_request ##0 s_q.ctrl_b[`CTRL_FLAG_BIT])
    else $error("tick edge did not raise interrupt");
  a_read_clears_irq: assert property (s_flag_read_quiet |=>
    !timer_interrupt_request && !s_q.ctrl_b[`CTRL_FLAG_BIT])
    else $error("flag read did not clear interrupt");
  a_inhibit_hold: assert property (wr && port_b &&
    cpu_addr[`ADDR_CTRL_BIT] && cpu_wdata[5:3] == `CTRL_HOLD_MODE |=>
    timer_inhibit_output)
    else $error("timer inhibit not asserted");
endmodule : fade_channel_port_adapter

// *** src/lane_if.sv ***
// carrier between the adapter and one peripheral lane
`timescale 1ns/1ps
interface lane_if;
  logic wr_dir;
  logic wr_out;
  logic [7:0] wdata;
  logic [7:0] pin_in;
  logic [7:0] out_q;
  logic [7:0] dir_q;
  logic [7:0] read_val;
  modport lane (input wr_dir, wr_out, wdata, pin_in,
                output out_q, dir_q, read_val);
  modport ctrl (output wr_dir, wr_out, wdata, pin_in,
                input out_q, dir_q, read_val);
endinterface : lane_if

// *** src/port_lane.sv ***
// one peripheral lane: output data and direction registers
`timescale 1ns/1ps
`include "fade_adapter_consts.svh"
module port_lane #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // adapter side
  lane_if.lane lp
);
  fade_adapter_pkg::lane_state_t s_q;
  fade_adapter_pkg::lane_state_t s_d;

  if (WIDTH != 8) begin : g_width_check
    $error("port_lane serves only an 8 bit lane");
  end

  always_comb begin
    s_d = s_q;
    if (lp.wr_dir) begin
      s_d.dir = lp.wdata;
    end
    if (lp.wr_out) begin
      s_d.out = lp.wdata;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= {`REG_RESET, `REG_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign lp.out_q = s_q.out;
  assign lp.dir_q = s_q.dir;
  // lines set as inputs read the pin, outputs read back the register
  assign lp.read_val = (s_q.dir & s_q.out) | (~s_q.dir & lp.pin_in);

  a_input_reads_pin: assert property (@(posedge mclk) disable iff (!reset_n)
    ((lp.read_val & ~lp.dir_q) == (lp.pin_in & ~lp.dir_q)))
    else $error("input line does not read its pin");
  a_reset_all_input: assert property (@(posedge mclk)
    $rose(reset_n) |-> (lp.dir_q == 8'h00 && lp.out_q == 8'h00))
    else $error("lane not cleared by reset");
endmodule : port_lane

// *** verification/fade_channel_port_adapter_tb.sv ***
// self-checking bench for the fade channel port adapter
`timescale 1ns/1ps
module fade_channel_port_adapter_tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic cpu_valid = 1'b0;
  logic cpu_read = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] chan_pin_in = 8'hA5;
  logic fire = 1'b0;
  logic dac_above = 1'b0;
  logic [7:0] cpu_rdata, chan_pin_out, chan_pin_oe_n;
  logic [7:0] flag_pin_out, flag_pin_oe_n;
  logic [1:0] digitise_select;
  logic channel_done_strobe, blink_flag, down_fade_flag, mimic_on_flag;
  logic key_select_flag, tick, cmp_out, inhibit, irq;
  int bad_count = 0;
  int compares = 0;
  time cycle_start = 0;

  always #5 mclk = ~mclk;

  fade_channel_port_adapter dut (.mclk(mclk), .reset_n(reset_n),
    .cpu_addr(cpu_addr), .cpu_valid(cpu_valid), .cpu_read(cpu_read),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
    .chan_pin_oe_n(chan_pin_oe_n),
    .channel_done_strobe(channel_done_strobe),
    .flag_pin_in({cmp_out, 7'h2A}), .flag_pin_out(flag_pin_out),
    .flag_pin_oe_n(flag_pin_oe_n), .blink_flag(blink_flag),
    .down_fade_flag(down_fade_flag), .mimic_on_flag(mimic_on_flag),
    .key_select_flag(key_select_flag), .digitise_select(digitise_select),
    .timer_tick_input(tick), .timer_inhibit_output(inhibit),
    .timer_interrupt_request(irq));

  fade_timer_model partner (.mclk(mclk), .reset_n(reset_n), .fire(fire),
    .dac_above(dac_above), .inhibit(inhibit), .tick(tick),
    .cmp_out(cmp_out));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask : chk1

  // one access; returns one settled step after the answer edge
  task automatic acc(input logic [15:0] a, input logic rd,
                     input logic [7:0] d);
    @(posedge mclk);
    cpu_addr <= a;
    cpu_read <= rd;
    cpu_wdata <= d;
    cpu_valid <= 1'b1;
    @(posedge mclk);
    cpu_valid <= 1'b0;
    #1;
  endtask : acc

  task automatic shot();
    @(posedge mclk);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask : shot

  task automatic reset_values();
    acc(16'h0A01, 1'b1, 8'h00);
    chk8(cpu_rdata, 8'h00);
    acc(16'h0A03, 1'b1, 8'h00);
    chk8(cpu_rdata, 8'h00);
    chk8(chan_pin_oe_n, 8'hFF);
    chk1(irq, 1'b0);
  endtask : reset_values

  task automatic channel_port();
    acc(16'h0A04, 1'b0, 8'hFF);
    chk8(chan_pin_oe_n, 8'hFF);
    acc(16'h0A00, 1'b0, 8'hFF);
    chk8(chan_pin_oe_n, 8'h00);
    acc(16'h0A00, 1'b1, 8'h00);
    chk8(cpu_rdata, 8'hFF);
    acc(16'h0A01, 1'b0, 8'h2C);
    acc(16'h0A00, 1'b0, 8'h05);
    chk8(chan_pin_out, 8'h05);
    acc(16'h0A00, 1'b1, 8'h00);
    chk8(cpu_rdata, 8'h05);
    chk1(channel_done_strobe, 1'b1);
    @(posedge mclk);
    #1;
    chk1(channel_done_strobe, 1'b0);
    acc(16'h0A01, 1'b0, 8'hFF);
    acc(16'h0A01, 1'b1, 8'h00);
    chk8(cpu_rdata, 8'h3F);
    chk1(channel_done_strobe, 1'b1);
    acc(16'h0A01, 1'b0, 8'h28);
    acc(16'h0A00, 1'b0, 8'h3C);
    acc(16'h0A01, 1'b0, 8'h2C);
    chk1(channel_done_strobe, 1'b0);
    acc(16'h0A00, 1'b1, 8'h00);
    chk8(cpu_rdata, 8'h85);
    acc(16'h0A01, 1'b0, 8'h28);
    acc(16'h0A00, 1'b0, 8'hFF);
    acc(16'h0A01, 1'b0, 8'h2C);
  endtask : channel_port

  task automatic flag_port();
    acc(16'h0A02, 1'b0, 8'h7F);
    chk8(flag_pin_oe_n, 8'h80);
    acc(16'h0A03, 1'b0, 8'h04);
    acc(16'h0A02, 1'b0, 8'h16);
    chk1(blink_flag, 1'b0);
    chk1(down_fade_flag, 1'b1);
    chk1(mimic_on_flag, 1'b1);
    chk1(key_select_flag, 1'b1);
    chk8(flag_pin_out, 8'h16);
    chk8({6'h00, digitise_select}, 8'h01);
    dac_above <= 1'b0;
    acc(16'h0A02, 1'b1, 8'h00);
    chk8(cpu_rdata, 8'h96);
    dac_above <= 1'b1;
    acc(16'h0A02, 1'b1, 8'h00);
    chk8(cpu_rdata, 8'h16);
  endtask : flag_port

  task automatic timer_path();
    acc(16'h0A03, 1'b0, 8'h05);
    shot();
    chk1(irq, 1'b1);
    acc(16'h0A03, 1'b1, 8'h00);
    chk8(cpu_rdata, 8'h85);
    acc(16'h0A02, 1'b1, 8'h00);
    chk1(irq, 1'b0);
    acc(16'h0A03, 1'b0, 8'h3D);
    chk1(inhibit, 1'b1);
    shot();
    chk1(irq, 1'b0);
    acc(16'h0A03, 1'b0, 8'h05);
    chk1(inhibit, 1'b0);
    // rising edge mode must ignore the falling half of the shot
    acc(16'h0A03, 1'b0, 8'h07);
    @(posedge mclk);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk1(irq, 1'b0);
    @(posedge mclk);
    #1;
    chk1(irq, 1'b1);
    acc(16'h0A02, 1'b1, 8'h00);
    chk1(irq, 1'b0);
  endtask : timer_path

  // one fade cycle over three channels, top channel first
  task automatic fade_cycle();
    logic [7:0] ch;
    logic [7:0] flags;
    chk1($time - cycle_start <= 36000000, 1'b1);
    cycle_start = $time;
    ch = 8'h02;
    acc(16'h0A00, 1'b0, ch);
    repeat (3) begin
      flags = {2'h0, ch[0], 5'h04};
      acc(16'h0A02, 1'b0, flags);
      chk8(flag_pin_out, flags);
      chk1(blink_flag, ch[0]);
      acc(16'h0A00, 1'b1, 8'h00);
      chk8(cpu_rdata, ch);
      chk1(channel_done_strobe, 1'b1);
      ch = ch - 8'h01;
      acc(16'h0A00, 1'b0, ch);
    end
    chk8(chan_pin_out, 8'hFF);
  endtask : fade_cycle

  task automatic end_of_test();
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    reset_values();
    channel_port();
    flag_port();
    timer_path();
    fade_cycle();
    fade_cycle();
    end_of_test();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
endmodule : fade_channel_port_adapter_tb

// *** verification/fade_timer_model.sv ***
// model of the 4 ms timer and the conversion comparator
`timescale 1ns/1ps
module fade_timer_model (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // bench side
  input wire logic fire,
  input wire logic dac_above,
  // adapter side
  input wire logic inhibit,
  output logic tick,
  output logic cmp_out
);
  logic [1:0] low_q;
  // tick idles high; a shot pulls it low for two cycles
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      low_q <= 2'h0;
    end else if (fire && !inhibit) begin
      low_q <= 2'h2;
    end else if (low_q != 2'h0) begin
      low_q <= low_q - 2'h1;
    end
  end
  assign tick = (low_q == 2'h0);
  // zero when the converter output is above the level
  assign cmp_out = ~dac_above;
endmodule : fade_timer_model
